// ==== rtl/cwd_map.vh ====
// Constants for the clock watchdog and frequency programming block
`ifndef CWD_MAP_VH
`define CWD_MAP_VH
`define CWD_TICK_FAST_MS 150
`define CWD_TICK_SLOW_MS 2500
`define CWD_CLK_KHZ 250000
`define CWD_TICK_FAST_CYC (`CWD_TICK_FAST_MS * `CWD_CLK_KHZ)
`define CWD_TICK_SLOW_CYC (`CWD_TICK_SLOW_MS * `CWD_CLK_KHZ)
`define CWD_RST_PULSE_CYC 8
`define CWD_COUNT_W 5
`define CWD_MULT_W 8
`define CWD_DIV_W 7
`define CWD_OPERAND_BIAS 3
`define CWD_COUNT_RST 5'h1F
`define CWD_MULT_RST 8'h00
`define CWD_DIV_RST 7'h00
`endif

// ==== rtl/cwd_pulse.v ====
// Fixed-length pulse stretcher for the system reset output
`timescale 1ns/10ps
module cwd_pulse #(
    parameter LEN = 8
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    input wire clk_en,
    // Trigger and pulse
    input wire trig,
    output reg pulse_q
);
    reg [7:0] cnt_q;
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 8'h00;
            pulse_q <= 1'b0;
        end else if (clk_en) begin
            if (trig) begin
                cnt_q <= LEN[7:0] - 8'h01;
                pulse_q <= 1'b1;
            end else if (cnt_q != 8'h00) begin
                cnt_q <= cnt_q - 8'h01;
            end else begin
                pulse_q <= 1'b0;
            end
        end
    end
endmodule

// ==== rtl/cwd_watchdog.v ====
// Watchdog timer, reset generation and CPU frequency selection
`timescale 1ns/10ps
`include "cwd_map.vh"
module cwd_watchdog #(
    parameter TICK_FAST_CYC = `CWD_TICK_FAST_CYC,
    parameter TICK_SLOW_CYC = `CWD_TICK_SLOW_CYC,
    parameter RST_PULSE_CYC = `CWD_RST_PULSE_CYC
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    input wire clk_en,
    // Register write strobes and data from the management interface
    input wire timeout_flag_wr,
    input wire timeout_flag_wdata,
    input wire cfg_wr,
    input wire [4:0] timeout_count_field,
    input wire tick_unit_select,
    input wire reset_on_timeout_enable,
    input wire reset_on_freq_change_enable,
    input wire watchdog_enable,
    // Frequency programming
    input wire programmable_freq_enable,
    input wire freq_override,
    input wire [4:0] freq_strap_pins,
    input wire [4:0] freq_select_bits,
    input wire freq_wr,
    input wire [7:0] cpu_multiplier_value,
    input wire [6:0] cpu_divider_value,
    input wire recovery_source_select,
    input wire [7:0] recovery_multiplier_value,
    input wire [6:0] recovery_divider_value,
    // Status and results
    output reg timeout_flag_q,
    output reg watchdog_running_q,
    output reg [4:0] ticks_left_q,
    output reg recovery_active_q,
    output reg prog_active_q,
    output reg [4:0] gear_select_q,
    output reg [8:0] freq_mult_q,
    output reg [7:0] freq_div_q,
    output wire sys_reset_pulse_q
);
    localparam ST_IDLE = 3'b001;
    localparam ST_RUN = 3'b010;
    localparam ST_DONE = 3'b100;

    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [31:0] prescale_q;
    reg [4:0] count_cfg_q;
    reg unit_q;
    reg rst_watchdog_enable_q;
    reg rst_fc_en_q;
    reg watchdog_enable_q;
    reg [4:0] strap_q;
    reg strap_taken_q;
    reg timeout_evt;
    reg freq_change;
    wire tick_end;
    wire [31:0] tick_len;
    reg [4:0] count_cfg_d;
    reg unit_d;
    reg rst_watchdog_enable_d;
    reg rst_fc_en_d;
    reg watchdog_enable_d;
    reg [4:0] strap_d;
    reg strap_taken_d;
    reg [31:0] prescale_d;
    reg [4:0] ticks_left_d;
    reg timeout_flag_d;
    reg flag_clear;
    reg recovery_active_d;
    reg prog_active_d;
    reg [4:0] gear_select_d;
    reg [8:0] freq_mult_d;
    reg [7:0] freq_div_d;
    reg strap_gear;
    reg [7:0] mult_src;
    reg [6:0] div_src;
    reg rst_trig;

    // Register copies of the configuration bits
    always @* begin
        count_cfg_d = count_cfg_q;
        unit_d = unit_q;
        rst_watchdog_enable_d = rst_watchdog_enable_q;
        rst_fc_en_d = rst_fc_en_q;
        watchdog_enable_d = watchdog_enable_q;
        if (cfg_wr) begin
            count_cfg_d = timeout_count_field;
            unit_d = tick_unit_select;
            rst_watchdog_enable_d = reset_on_timeout_enable;
            rst_fc_en_d = reset_on_freq_change_enable;
            watchdog_enable_d = watchdog_enable;
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_cfg_q <= `CWD_COUNT_RST;
            unit_q <= 1'b0;
            rst_watchdog_enable_q <= 1'b0;
            rst_fc_en_q <= 1'b0;
            watchdog_enable_q <= 1'b0;
        end else if (clk_en) begin
            count_cfg_q <= count_cfg_d;
            unit_q <= unit_d;
            rst_watchdog_enable_q <= rst_watchdog_enable_d;
            rst_fc_en_q <= rst_fc_en_d;
            watchdog_enable_q <= watchdog_enable_d;
        end
    end

    // Strap value captured once after reset release, not under the reset itself
    always @* begin
        strap_d = strap_q;
        strap_taken_d = strap_taken_q;
        if (!strap_taken_q) begin
            strap_d = freq_strap_pins;
            strap_taken_d = 1'b1;
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_q <= 5'h00;
            strap_taken_q <= 1'b0;
        end else if (clk_en) begin
            strap_q <= strap_d;
            strap_taken_q <= strap_taken_d;
        end
    end

    assign tick_len = unit_q ? TICK_SLOW_CYC : TICK_FAST_CYC;
    assign tick_end = (prescale_q == tick_len - 32'h1);

    // Events of this cycle; a frozen cycle takes no strobe and ends no tick
    always @* begin
        freq_change = clk_en && freq_wr;
        timeout_evt = clk_en && (state_q == ST_RUN) && tick_end && (ticks_left_q == 5'h00) && watchdog_enable_q;
    end

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (watchdog_enable_q && freq_change) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!watchdog_enable_q) begin
                    state_d = ST_IDLE;
                end else if (timeout_evt) begin
                    state_d = ST_DONE;
                end
            end
            ST_DONE: begin
                if (!watchdog_enable_q) begin
                    state_d = ST_IDLE;
                end else if (freq_change) begin
                    state_d = ST_RUN;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Countdown; a field value v runs v+1 ticks, so the count ends after tick zero
    always @* begin
        prescale_d = prescale_q + 32'h1;
        ticks_left_d = ticks_left_q;
        if (state_q != ST_RUN || state_d != ST_RUN) begin
            prescale_d = 32'h0;
            ticks_left_d = count_cfg_q;
        end else if (tick_end) begin
            prescale_d = 32'h0;
            ticks_left_d = ticks_left_q - 5'h01;
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            prescale_q <= 32'h0;
            ticks_left_q <= `CWD_COUNT_RST;
            watchdog_running_q <= 1'b0;
        end else if (clk_en) begin
            state_q <= state_d;
            watchdog_running_q <= (state_d == ST_RUN);
            prescale_q <= prescale_d;
            ticks_left_q <= ticks_left_d;
        end
    end

    // Sticky flag; a time-out in the clearing cycle wins over the clear
    always @* begin
        flag_clear = timeout_flag_wr && timeout_flag_wdata;
        timeout_flag_d = timeout_flag_q;
        if (timeout_evt) begin
            timeout_flag_d = 1'b1;
        end else if (flag_clear) begin
            timeout_flag_d = 1'b0;
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            timeout_flag_q <= 1'b0;
        end else if (clk_en) begin
            timeout_flag_q <= timeout_flag_d;
        end
    end

    // Recovery takes over at a time-out and lasts until the next frequency change
    always @* begin
        recovery_active_d = recovery_active_q;
        if (timeout_evt) begin
            recovery_active_d = 1'b1;
        end else if (freq_change) begin
            recovery_active_d = 1'b0;
        end
    end

    // A strap-sourced recovery ignores the override, so a bad select cannot block recovery
    always @* begin
        strap_gear = !freq_override;
        mult_src = cpu_multiplier_value;
        div_src = cpu_divider_value;
        prog_active_d = programmable_freq_enable;
        if (recovery_active_d) begin
            prog_active_d = recovery_source_select;
            mult_src = recovery_multiplier_value;
            div_src = recovery_divider_value;
            if (!recovery_source_select) begin
                strap_gear = 1'b1;
            end
        end
        if (strap_gear) begin
            gear_select_d = strap_q;
        end else begin
            gear_select_d = freq_select_bits;
        end
        // The ratio above one is the writer's job; no check is made here
        freq_mult_d = {1'b0, mult_src} + 9'h003;
        freq_div_d = {1'b0, div_src} + 8'h03;
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            recovery_active_q <= 1'b0;
            prog_active_q <= 1'b0;
            gear_select_q <= 5'h00;
            freq_mult_q <= 9'h000;
            freq_div_q <= 8'h00;
        end else if (clk_en) begin
            recovery_active_q <= recovery_active_d;
            prog_active_q <= prog_active_d;
            gear_select_q <= gear_select_d;
            freq_mult_q <= freq_mult_d;
            freq_div_q <= freq_div_d;
        end
    end

    // Either cause starts one pulse; a second cause during a pulse restarts it
    always @* begin
        rst_trig = 1'b0;
        if (timeout_evt && rst_watchdog_enable_q) begin
            rst_trig = 1'b1;
        end
        if (freq_change && rst_fc_en_q) begin
            rst_trig = 1'b1;
        end
    end

    cwd_pulse #(
        .LEN(RST_PULSE_CYC)
    ) u_rst_pulse (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .trig(rst_trig),
        .pulse_q(sys_reset_pulse_q)
    );
endmodule

// ==== dv/cwd_checker.sv ====
// Assertion checker for the clock watchdog block
`timescale 1ns/10ps
module cwd_checker #(parameter RST_PULSE_CYC = 8) (
    // Clock, reset and strobes
    input wire sys_clk, input wire rst_n, input wire clk_en, input wire cfg_wr, input wire freq_wr,
    input wire timeout_flag_wr, input wire timeout_flag_wdata, input wire [4:0] timeout_count_field,
    input wire reset_on_timeout_enable, input wire reset_on_freq_change_enable, input wire watchdog_enable,
    input wire programmable_freq_enable, input wire [7:0] cpu_multiplier_value,
    // Results
    input wire timeout_flag_q, input wire watchdog_running_q, input wire [4:0] ticks_left_q,
    input wire [8:0] freq_mult_q, input wire sys_reset_pulse_q
);
    // Shadow of the loaded enables, since the ports only carry write data
    reg rto_q, rfc_q, wen_q;
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            {rto_q, rfc_q, wen_q} <= 3'h0;
        end else if (cfg_wr && clk_en) begin
            {rto_q, rfc_q, wen_q} <= {reset_on_timeout_enable, reset_on_freq_change_enable, watchdog_enable};
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_pulse;
        sys_reset_pulse_q[*8] ##1 !sys_reset_pulse_q;
    endsequence
    pulse_len_a: assert property ($rose(sys_reset_pulse_q) |-> s_pulse) else $error("reset pulse length wrong");
    flag_clear_a: assert property (timeout_flag_wr && timeout_flag_wdata && clk_en && !watchdog_running_q
        |=> !timeout_flag_q) else $error("flag not cleared");
    flag_hold_a: assert property (timeout_flag_q && !(timeout_flag_wr && timeout_flag_wdata && clk_en)
        |=> timeout_flag_q) else $error("flag dropped");
    ticks_reload_a: assert property (cfg_wr && clk_en && !watchdog_enable
        |=> ##1 (!watchdog_running_q && ticks_left_q == $past(timeout_count_field, 2))) else $error("no reload");
    mult_calc_a: assert property (freq_wr && clk_en && programmable_freq_enable
        |=> freq_mult_q == $past(cpu_multiplier_value) + 9'h003) else $error("multiplier wrong");
    fc_reset_a: assert property (freq_wr && clk_en && rfc_q |-> ##[1:2] sys_reset_pulse_q)
        else $error("no reset on change");
    pulse_cause_a: assert property ($rose(sys_reset_pulse_q) |-> (rto_q && timeout_flag_q)
        || $past(freq_wr && rfc_q, 1) || $past(freq_wr && rfc_q, 2)) else $error("reset without cause");
    run_start_a: assert property (freq_wr && clk_en && wen_q |-> ##[1:2] watchdog_running_q)
        else $error("countdown not started");
endmodule
bind cwd_watchdog cwd_checker #(.RST_PULSE_CYC(RST_PULSE_CYC)) u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
    .clk_en(clk_en), .cfg_wr(cfg_wr), .freq_wr(freq_wr), .timeout_flag_wr(timeout_flag_wr),
    .timeout_flag_wdata(timeout_flag_wdata), .timeout_count_field(timeout_count_field),
    .reset_on_timeout_enable(reset_on_timeout_enable), .reset_on_freq_change_enable(reset_on_freq_change_enable),
    .watchdog_enable(watchdog_enable), .programmable_freq_enable(programmable_freq_enable),
    .cpu_multiplier_value(cpu_multiplier_value), .timeout_flag_q(timeout_flag_q),
    .watchdog_running_q(watchdog_running_q), .ticks_left_q(ticks_left_q), .freq_mult_q(freq_mult_q),
    .sys_reset_pulse_q(sys_reset_pulse_q));

// ==== dv/cwd_host.sv ====
// Management software model that writes the watchdog controls
`timescale 1ns/10ps
module cwd_host (
    input wire sys_clk,
    output reg twr, output reg twd, output reg cwr, output reg [4:0] cnt, output reg tus,
    output reg rto, output reg rfc, output reg wen, output reg fwr, output reg [7:0] n, output reg [6:0] m
);
    initial {twr, twd, cwr, cnt, tus, rto, rfc, wen, fwr, n, m} = 0;
    task cfg(input [4:0] v, input u, input r, input f, input e);
        @(posedge sys_clk);
        cwr <= 1'b1;
        {cnt, tus, rto, rfc, wen} <= {v, u, r, f, e};
        @(posedge sys_clk);
        cwr <= 1'b0;
    endtask
    // Caller keeps (a+3)/(b+3) above one
    task fw(input [7:0] a, input [6:0] b);
        @(posedge sys_clk);
        fwr <= 1'b1;
        {n, m} <= {a, b};
        @(posedge sys_clk);
        fwr <= 1'b0;
    endtask
    task fl(input d);
        @(posedge sys_clk);
        {twr, twd} <= {1'b1, d};
        @(posedge sys_clk);
        twr <= 1'b0;
    endtask
endmodule

// ==== dv/cwd_watchdog_tb_top.sv ====
// Self-checking bench for the clock watchdog block
`timescale 1ns/10ps
module cwd_watchdog_tb_top;
    reg sys_clk = 0, rst_n = 0, clk_en = 1, prog = 1, ovr = 0, rsel = 0;
    reg [4:0] strap = 5'h0A, sel = 5'h15;
    reg [7:0] rmul = 8'h20;
    reg [6:0] rdiv = 7'h05;
    wire twr, twd, cwr, tus, rto, rfc, wen, fwr, flag, run, rec, pa, pulse;
    wire [4:0] cnt, tl, gs;
    wire [7:0] n, fd;
    wire [6:0] m;
    wire [8:0] fm;
    integer n_fail = 0, comparisons = 0, cyc = 0, c;
    always #2 sys_clk = ~sys_clk;
    cwd_host h (.sys_clk(sys_clk), .twr(twr), .twd(twd), .cwr(cwr), .cnt(cnt), .tus(tus), .rto(rto), .rfc(rfc),
        .wen(wen), .fwr(fwr), .n(n), .m(m));
    // Short ticks keep the run brief
    cwd_watchdog #(.TICK_FAST_CYC(4), .TICK_SLOW_CYC(8), .RST_PULSE_CYC(8)) dut (.sys_clk(sys_clk),
        .rst_n(rst_n), .clk_en(clk_en), .timeout_flag_wr(twr), .timeout_flag_wdata(twd), .cfg_wr(cwr),
        .timeout_count_field(cnt), .tick_unit_select(tus), .reset_on_timeout_enable(rto),
        .reset_on_freq_change_enable(rfc), .watchdog_enable(wen), .programmable_freq_enable(prog),
        .freq_override(ovr), .freq_strap_pins(strap), .freq_select_bits(sel), .freq_wr(fwr),
        .cpu_multiplier_value(n), .cpu_divider_value(m), .recovery_source_select(rsel),
        .recovery_multiplier_value(rmul), .recovery_divider_value(rdiv), .timeout_flag_q(flag),
        .watchdog_running_q(run), .ticks_left_q(tl), .recovery_active_q(rec), .prog_active_q(pa),
        .gear_select_q(gs), .freq_mult_q(fm), .freq_div_q(fd), .sys_reset_pulse_q(pulse));
    task chk(input logic [31:0] g, input logic [31:0] e);
        comparisons = comparisons + 1;
        if (g !== e) begin
            n_fail = n_fail + 1;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task tick;
        @(posedge sys_clk);
        #1;
    endtask
    // Cycles until the flag sets, bounded so a dead countdown cannot hang
    task wfl(input integer t);
        c = 0;
        while (flag !== 1'b1 && c < 200) begin
            tick;
            c = c + 1;
        end
        chk(c >= t - 2 && c <= t + 3, 1);
    endtask
    task complete_run;
        if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail = n_fail + 1;
            complete_run;
        end
    end
    initial begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        tick;
        chk(flag, 0);
        chk(tl, 5'h1F);
        h.cfg(5'h02, 0, 1, 0, 1);
        h.fw(8'hC8, 7'h2D);
        tick;
        chk({pa, fm, fd}, {1'b1, 9'h0CB, 8'h30});
        chk(pulse, 0);
        wfl(12);
        chk({rec, pa}, {1'b1, 1'b0});
        h.fl(0);
        tick;
        chk(flag, 1);
        h.fl(1);
        tick;
        chk(flag, 0);
        h.cfg(5'h01, 1, 0, 1, 1);
        h.fw(8'h40, 7'h10);
        tick;
        chk(pulse, 1);
        wfl(16);
        repeat (3) tick;
        chk(pulse, 0);
        h.fl(1);
        ovr <= 1'b1;
        tick;
        chk(gs, strap);
        h.cfg(5'h03, 0, 0, 0, 1);
        h.fw(8'h50, 7'h10);
        repeat (5) tick;
        chk(gs, sel);
        h.cfg(5'h06, 0, 0, 0, 0);
        tick;
        chk({run, tl}, {1'b0, 5'h06});
        h.cfg(5'h00, 0, 1, 0, 1);
        {rsel, rmul, rdiv, prog} <= {1'b1, 8'h30, 7'h07, 1'b0};
        h.fw(8'h60, 7'h20);
        clk_en <= 1'b0;
        repeat (6) tick;
        chk({run, flag, pulse, pa}, 4'b1000);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        wfl(4);
        chk({rec, pulse, pa, fm, fd}, {1'b1, 1'b1, 1'b1, 9'h033, 8'h0A});
        complete_run;
    end
endmodule
